//--- rtl/sms_pkg.sv
package sms_pkg;

  // Clock of both ends.
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;

  // Standby control byte layout.
  localparam int SBC_WIDTH = 8;
  localparam int SBC_STOP_POS = 1;
  localparam logic [7:0] SBC_RESET = 8'h00;

  // Oscillator settle time select and its time unit.
  localparam int SETTLE_SEL_WIDTH = 3;
  localparam logic [2:0] SETTLE_SEL_RESET = 3'h0;
  localparam int SETTLE_UNIT_NS = 40960;
  localparam int SETTLE_UNIT_CYC = (SETTLE_UNIT_NS * CLK_MHZ) / 1000;
  localparam int SETTLE_CNT_WIDTH = 16;

  // Wake source indices.
  localparam int NUM_SRC = 4;
  localparam logic [1:0] SRC_NMI = 2'h0;
  localparam logic [1:0] SRC_EXT_A = 2'h1;
  localparam logic [1:0] SRC_EXT_B = 2'h2;
  localparam logic [1:0] SRC_WATCH = 2'h3;

  // Service priority, level 0 is the highest.
  localparam int PRIO_WIDTH = 2;
  localparam logic [1:0] PRIO_LOWEST = 2'h3;

  // Outcome of a wake request under the current interrupt flags.
  typedef enum logic [1:0] {
    CL_STAY,
    CL_ACK,
    CL_RESUME
  } sms_class_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_STOP,
    ST_SETTLE
  } sms_state_t;

endpackage

//--- rtl/sms_if.sv
`timescale 1ns/1ps
interface sms_if;
  import sms_pkg::*;

  // Driven by the CPU end.
  logic sbc_wr;
  logic [SBC_WIDTH-1:0] sbc_byte;
  logic [SETTLE_SEL_WIDTH-1:0] settle_sel;
  logic ext_clk;
  logic nmi_edge_rise;
  logic [NUM_SRC-1:0] mask;
  logic [NUM_SRC-1:0] macro_en;
  logic [NUM_SRC*PRIO_WIDTH-1:0] prio;
  logic int_en;
  logic lvl_relax;
  logic svc_active;
  logic [PRIO_WIDTH-1:0] svc_prio;
  logic nmi_busy_hi;
  logic [NUM_SRC-1:0] req_clr;

  // Driven by the standby controller.
  logic clk_gate_en;
  logic ack_valid;
  logic [1:0] ack_src;
  logic resume;
  logic [NUM_SRC-1:0] pending;

  modport dev (
    input sbc_wr, sbc_byte, settle_sel, ext_clk, nmi_edge_rise, mask, macro_en, prio,
    input int_en, lvl_relax, svc_active, svc_prio, nmi_busy_hi, req_clr,
    output clk_gate_en, ack_valid, ack_src, resume, pending
  );

  modport cpu (
    output sbc_wr, sbc_byte, settle_sel, ext_clk, nmi_edge_rise, mask, macro_en, prio,
    output int_en, lvl_relax, svc_active, svc_prio, nmi_busy_hi, req_clr,
    input clk_gate_en, ack_valid, ack_src, resume, pending
  );

endinterface

//--- rtl/sms_cpu.sv
`timescale 1ns/1ps
module sms_cpu
  import sms_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  sms_if.cpu LINK,
  input wire logic SBC_MOV_IN,
  input wire logic [SBC_WIDTH-1:0] SBC_BYTE_IN,
  input wire logic [SETTLE_SEL_WIDTH-1:0] SETTLE_SEL_IN,
  input wire logic EXT_CLK_SEL_IN,
  input wire logic EXT_CLOCK_SYS_IN,
  input wire logic NMI_EDGE_RISE_IN,
  input wire logic [NUM_SRC-1:0] MASK_IN,
  input wire logic [NUM_SRC-1:0] MACRO_EN_IN,
  input wire logic [NUM_SRC*PRIO_WIDTH-1:0] PRIO_IN,
  input wire logic INT_EN_IN,
  input wire logic LVL_RELAX_IN,
  input wire logic SVC_ACTIVE_IN,
  input wire logic [PRIO_WIDTH-1:0] SVC_PRIO_IN,
  input wire logic NMI_BUSY_HI_IN,
  input wire logic [NUM_SRC-1:0] REQ_CLR_IN,
  output logic CPU_RUN_OUT,
  output logic ACK_OUT,
  output logic [1:0] ACK_SRC_OUT,
  output logic RESUME_OUT,
  output logic [NUM_SRC-1:0] PENDING_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // dedicated move only.
  // The byte write only issues while the core runs, so a gated core cannot
  // send a second request.
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      LINK.sbc_wr <= 1'b0;
      LINK.sbc_byte <= SBC_RESET;
    end else if (CE_IN) begin
      LINK.sbc_wr <= SBC_MOV_IN & LINK.clk_gate_en;
      LINK.sbc_byte <= SBC_BYTE_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      LINK.settle_sel <= SETTLE_SEL_RESET;
      LINK.ext_clk <= 1'b0;
      LINK.nmi_edge_rise <= 1'b0;
      LINK.mask <= '1;
      LINK.macro_en <= '0;
      LINK.prio <= '1;
      LINK.int_en <= 1'b0;
      LINK.lvl_relax <= 1'b0;
      LINK.svc_active <= 1'b0;
      LINK.svc_prio <= PRIO_LOWEST;
      LINK.nmi_busy_hi <= 1'b0;
      LINK.req_clr <= '0;
    end else if (CE_IN) begin
      LINK.settle_sel <= SETTLE_SEL_IN;
      LINK.ext_clk <= EXT_CLK_SEL_IN | EXT_CLOCK_SYS_IN;
      LINK.nmi_edge_rise <= NMI_EDGE_RISE_IN;
      LINK.mask <= MASK_IN;
      LINK.macro_en <= MACRO_EN_IN;
      LINK.prio <= PRIO_IN;
      LINK.int_en <= INT_EN_IN;
      LINK.lvl_relax <= LVL_RELAX_IN;
      LINK.svc_active <= SVC_ACTIVE_IN;
      LINK.svc_prio <= SVC_PRIO_IN;
      LINK.nmi_busy_hi <= NMI_BUSY_HI_IN;
      LINK.req_clr <= REQ_CLR_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ACK_OUT <= 1'b0;
      ACK_SRC_OUT <= SRC_NMI;
      RESUME_OUT <= 1'b0;
      PENDING_OUT <= '0;
    end else if (CE_IN) begin
      ACK_OUT <= LINK.ack_valid;
      ACK_SRC_OUT <= LINK.ack_src;
      RESUME_OUT <= LINK.resume;
      PENDING_OUT <= LINK.pending;
    end
  end

  assign CPU_RUN_OUT = LINK.clk_gate_en;

endmodule

//--- rtl/sms_dev.sv
`timescale 1ns/1ps
// What this block does
// - Reset wake restarts normally, RAM kept.
// - Stop bit written one enters stop.
// - Only dedicated 8-bit move writes control.
// - Satisfied wake at write prevents stopping.
// - Stop halts oscillator, clock, CPU, peripherals.
// - Stop holds I/O lines and RAM.
// - Bus floats, refresh kept, hold acknowledge low.
// - Software clears converter enable before stop.
// - Oscillator input grounded unless external clock.
// - Only NMI, two pins, watch, reset wake.
// - Reset wakes regardless of interrupt flags.
// - NMI wakes always, acknowledged unless busy.
// - Busy NMI resumes next instruction, stays pending.
// - Enabled maskable wake acknowledged by priority.
// - Blocked maskable wake resumes, request pending.
// - Masked or macro-service source keeps stop.
// - Pending requests acknowledged once conditions allow.
// - Wake restarts oscillator, waits settle time.
// - NMI wakes only on selected edge.
module sms_dev
  import sms_pkg::*;
#(
  parameter int SETTLE_UNIT = SETTLE_UNIT_CYC
) (
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  sms_if.dev LINK,
  input wire logic NMI_PIN_IN,
  input wire logic WAKE_A_IN,
  input wire logic WAKE_B_IN,
  input wire logic WATCH_TIMER_IN,
  output logic STOPPED_OUT,
  output logic OSC_RUN_OUT,
  output logic OSC_PIN_GND_OUT,
  output logic PERIPH_HALT_OUT,
  output logic IO_HOLD_OUT,
  output logic RAM_RETAIN_OUT,
  output logic BUS_FLOAT_OUT,
  output logic HOLD_REQ_FLOAT_OUT,
  output logic HOLD_ACK_LOW_OUT,
  output logic REFRESH_HOLD_OUT
);

  sms_state_t state;
  logic [NUM_SRC-1:0] pin_now;
  logic [NUM_SRC-1:0] pin_prev;
  logic [NUM_SRC-1:0] edge_hit;
  logic [NUM_SRC-1:0] releasing;
  logic [NUM_SRC-1:0] ackable;
  logic [NUM_SRC-1:0] ack_clear;
  logic [SETTLE_CNT_WIDTH-1:0] settle_cnt;
  logic [1:0] wake_src;
  logic ext_clk_held;
  logic stop_req;

  ////////////////////////////////////////////////////////////////////////////
  // Decides what a pending request does under the current flags.
  function automatic sms_class_t classify(input logic [1:0] src);
    logic [PRIO_WIDTH-1:0] p;
    p = LINK.prio[src*PRIO_WIDTH +: PRIO_WIDTH];
    if (src == SRC_NMI) begin
      classify = LINK.nmi_busy_hi ? CL_RESUME : CL_ACK;
    end else if (LINK.mask[src] || LINK.macro_en[src]) begin
      classify = CL_STAY;
    end else if (!LINK.int_en) begin
      classify = CL_RESUME;
    end else if (!LINK.svc_active || LINK.svc_prio > p) begin
      classify = CL_ACK;
    end else if (LINK.svc_prio == p && p == PRIO_LOWEST && !LINK.lvl_relax) begin
      classify = CL_ACK;
    end else begin
      classify = CL_RESUME;
    end
  endfunction

  // Lowest index wins, so NMI always comes first.
  function automatic logic [1:0] first_set(input logic [NUM_SRC-1:0] v);
    first_set = SRC_NMI;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 2'(i);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // wake sources only.
  assign pin_now = {WATCH_TIMER_IN, WAKE_B_IN, WAKE_A_IN, NMI_PIN_IN};

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pin_prev <= '0;
    end else if (CE_IN) begin
      pin_prev <= pin_now;
    end
  end

  assign edge_hit[0] = LINK.nmi_edge_rise ? (pin_now[0] & ~pin_prev[0]) :
                                            (~pin_now[0] & pin_prev[0]);

  genvar g;
  generate
    for (g = 1; g < NUM_SRC; g++) begin : g_edge
      assign edge_hit[g] = pin_now[g] & ~pin_prev[g];
    end
    for (g = 0; g < NUM_SRC; g++) begin : g_class
      assign releasing[g] = LINK.pending[g] && (classify(2'(g)) != CL_STAY);
      assign ackable[g] = LINK.pending[g] && (classify(2'(g)) == CL_ACK);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // automatic pending acknowledge.
  // Acknowledge only while the core runs; one source per cycle.
  assign ack_clear = (state == ST_RUN && |ackable) ?
                     (NUM_SRC'(1) << first_set(ackable)) : '0;

  // A new edge in the cycle of a clear keeps the request set.
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      LINK.pending <= '0;
    end else if (CE_IN) begin
      LINK.pending <= (LINK.pending & ~(ack_clear | LINK.req_clr)) | edge_hit;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      LINK.ack_valid <= 1'b0;
      LINK.ack_src <= SRC_NMI;
    end else if (CE_IN) begin
      LINK.ack_valid <= |ack_clear;
      LINK.ack_src <= first_set(ackable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stop bit decode.
  assign stop_req = LINK.sbc_wr && LINK.sbc_byte[SBC_STOP_POS];

  // reset overrides flags.
  // Reset only returns control to run; nothing here clears memory.
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state <= ST_RUN;
      settle_cnt <= '0;
      wake_src <= SRC_NMI;
      ext_clk_held <= 1'b0;
      LINK.resume <= 1'b0;
    end else if (CE_IN) begin
      LINK.resume <= 1'b0;
      case (state)
        ST_RUN: begin
          if (stop_req) begin
            if (|releasing) begin
              LINK.resume <= ~|ackable;
            end else begin
              state <= ST_STOP;
              ext_clk_held <= LINK.ext_clk;
            end
          end
        end
        ST_STOP: begin
          if (|releasing) begin
            state <= ST_SETTLE;
            wake_src <= first_set(releasing);
            settle_cnt <= SETTLE_CNT_WIDTH'((32'(LINK.settle_sel) + 1) * SETTLE_UNIT);
          end
        end
        ST_SETTLE: begin
          if (settle_cnt <= SETTLE_CNT_WIDTH'(1)) begin
            state <= ST_RUN;
            LINK.resume <= classify(wake_src) == CL_RESUME;
          end else begin
            settle_cnt <= settle_cnt - SETTLE_CNT_WIDTH'(1);
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gate follows state.
  // The gate comes from the state flop, so it drops the cycle after the write.
  assign LINK.clk_gate_en = state == ST_RUN;
  assign STOPPED_OUT = state != ST_RUN;

  assign OSC_RUN_OUT = state != ST_STOP;
  assign PERIPH_HALT_OUT = state != ST_RUN;

  // ground oscillator input.
  // Only with a crystal; an external driver would fight the ground.
  assign OSC_PIN_GND_OUT = (state == ST_STOP) && !ext_clk_held;

  assign IO_HOLD_OUT = state != ST_RUN;
  assign RAM_RETAIN_OUT = state != ST_RUN;

  assign BUS_FLOAT_OUT = state != ST_RUN;
  assign HOLD_REQ_FLOAT_OUT = state != ST_RUN;
  assign HOLD_ACK_LOW_OUT = state != ST_RUN;
  assign REFRESH_HOLD_OUT = state != ST_RUN;

endmodule

//--- sim/sms_assertions.sv
`timescale 1ns/1ps
module sms_assertions
  import sms_pkg::*;
#(
  parameter int SETTLE_UNIT = 2
) (
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic sbc_wr,
  input wire logic [SBC_WIDTH-1:0] sbc_byte,
  input wire logic [SETTLE_SEL_WIDTH-1:0] settle_sel,
  input wire logic [NUM_SRC-1:0] mask,
  input wire logic [NUM_SRC-1:0] macro_en,
  input wire logic int_en,
  input wire logic svc_active,
  input wire logic nmi_busy_hi,
  input wire logic clk_gate_en,
  input wire logic ack_valid,
  input wire logic [1:0] ack_src,
  input wire logic resume,
  input wire logic [NUM_SRC-1:0] pending
);
  logic [15:0] low_cnt;
  logic waked;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  ////////////////////////////////////////////////////////////////////////////////
  // The settle span is counted here, since a repetition that long cannot be unrolled.
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      low_cnt <= 16'h0000;
    end else begin
      low_cnt <= clk_gate_en ? 16'h0000 : low_cnt + 16'h0001;
    end
  end
  // Set once a request able to end the stop is seen, so a causeless wake shows up.
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      waked <= 1'b0;
    end else if (clk_gate_en) begin
      waked <= 1'b0;
    end else if (pending[0] || (pending & ~(mask | macro_en) & 4'he) != 4'h0) begin
      waked <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_write;
    sbc_wr && clk_gate_en;
  endsequence
  sequence s_ack(logic [1:0] s);
    ack_valid && ack_src == s;
  endsequence
  property p_stop_enter;
    s_write ##0 (sbc_byte[SBC_STOP_POS] && pending == 4'h0) |=> !clk_gate_en;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop write kept clock");
  property p_settle;
    $rose(clk_gate_en) |-> low_cnt >= (settle_sel + 1) * SETTLE_UNIT + 1;
  endproperty
  a_settle: assert property (p_settle) else $error("settle too short");
  property p_wake_cause;
    $rose(clk_gate_en) |-> waked;
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without source");
  property p_ack_src;
    ack_valid |-> clk_gate_en && (($past(pending) >> ack_src) & 4'h1) != 4'h0;
  endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack without pending");
  property p_nmi_ack;
    $rose(clk_gate_en) && pending[0] && !nmi_busy_hi |=> s_ack(SRC_NMI);
  endproperty
  a_nmi_ack: assert property (p_nmi_ack) else $error("nmi not acked");
  property p_mask_ack;
    $rose(clk_gate_en) && pending == 4'h2 && !mask[1] && !macro_en[1] && int_en && !svc_active
      |=> s_ack(SRC_EXT_A);
  endproperty
  a_mask_ack: assert property (p_mask_ack) else $error("maskable not acked");
  property p_resume_ie;
    $rose(clk_gate_en) && !pending[0] && !int_en |-> ##[0:1] resume;
  endproperty
  a_resume_ie: assert property (p_resume_ie) else $error("no resume");
  property p_resume_pend;
    resume |-> pending != 4'h0 && !ack_valid;
  endproperty
  a_resume_pend: assert property (p_resume_pend) else $error("resume lost request");
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import sms_pkg::*;
  localparam int UNIT = 2;
  int mismatches = 0;
  int n_compared = 0;
  int n;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mov = 1'b0;
  logic [7:0] sb = 8'h00;
  logic [2:0] osc_settle_time_register = 3'h1;
  logic xsys = 1'b0;
  logic nr = 1'b1;
  logic [3:0] msk = 4'hf;
  logic [3:0] mse = 4'h0;
  logic [7:0] pri = 8'hff;
  logic ien = 1'b0;
  logic relax = 1'b1;
  logic svc = 1'b0;
  logic [1:0] sp = 2'h3;
  logic busy = 1'b0;
  logic nmi = 1'b0;
  logic wa = 1'b0;
  logic wb = 1'b0;
  logic wt = 1'b0;
  logic run, ack, rsm, stopd, osc, xg;
  logic [1:0] asrc;
  logic [3:0] pend;
  logic [6:0] st;
  always #20 clk = ~clk;
  sms_if link();
  sms_cpu sms_cpu_i (.CLK_IN(clk), .ARST_N_IN(rst_n), .CE_IN(1'b1), .LINK(link.cpu),
    .SBC_MOV_IN(mov), .SBC_BYTE_IN(sb), .SETTLE_SEL_IN(osc_settle_time_register), .EXT_CLK_SEL_IN(1'b0),
    .EXT_CLOCK_SYS_IN(xsys), .NMI_EDGE_RISE_IN(nr), .MASK_IN(msk), .MACRO_EN_IN(mse),
    .PRIO_IN(pri), .INT_EN_IN(ien), .LVL_RELAX_IN(relax), .SVC_ACTIVE_IN(svc),
    .SVC_PRIO_IN(sp),
    .NMI_BUSY_HI_IN(busy), .REQ_CLR_IN(4'h0), .CPU_RUN_OUT(run), .ACK_OUT(ack),
    .ACK_SRC_OUT(asrc), .RESUME_OUT(rsm), .PENDING_OUT(pend));
  sms_dev #(.SETTLE_UNIT(UNIT)) sms_dev_i (.CLK_IN(clk), .ARST_N_IN(rst_n), .CE_IN(1'b1),
    .LINK(link.dev), .NMI_PIN_IN(nmi), .WAKE_A_IN(wa), .WAKE_B_IN(wb), .WATCH_TIMER_IN(wt),
    .STOPPED_OUT(stopd), .OSC_RUN_OUT(osc), .OSC_PIN_GND_OUT(xg), .PERIPH_HALT_OUT(st[0]),
    .IO_HOLD_OUT(st[1]), .RAM_RETAIN_OUT(st[2]), .BUS_FLOAT_OUT(st[3]),
    .HOLD_REQ_FLOAT_OUT(st[4]), .HOLD_ACK_LOW_OUT(st[5]), .REFRESH_HOLD_OUT(st[6]));
  sms_assertions #(.SETTLE_UNIT(UNIT)) sms_assertions_i (.CLK_IN(clk), .ARST_N_IN(rst_n),
    .sbc_wr(link.sbc_wr), .sbc_byte(link.sbc_byte), .settle_sel(link.settle_sel),
    .mask(link.mask), .macro_en(link.macro_en), .int_en(link.int_en),
    .svc_active(link.svc_active),
    .nmi_busy_hi(link.nmi_busy_hi), .clk_gate_en(link.clk_gate_en),
    .ack_valid(link.ack_valid), .ack_src(link.ack_src), .resume(link.resume),
    .pending(link.pending));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic p);
    p = 1'b1;
    tick(1);
    p = 1'b0;
  endtask
  // Returns two edges after the write lands, when the stop state is visible.
  task automatic stop_wr(input logic [7:0] b);
    sb = b;
    pulse(mov);
    tick(2);
  endtask
  task automatic wait_hi(ref logic s, input string nm, output int c);
    c = 0;
    while (s !== 1'b1 && c < 200) begin
      tick(1);
      c++;
    end
    `CHK(nm, 1'b1, s)
  endtask
  task automatic note(input string nm);
    $display("Test %s ended, mismatches %0d", nm, mismatches);
  endtask
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 4000);
    mismatches++;
    stop_test();
  end
  initial begin
    tick(5);
    rst_n = 1'b1;
    tick(1);
    `CHK("run", 1'b1, run)
    `CHK("pend", 4'h0, pend)
    stop_wr(8'hfd);
    `CHK("stop", 1'b0, stopd)
    note("write");
    nmi = 1'b1;
    wait_hi(ack, "ack", n);
    `CHK("src", 2'h0, asrc)
    stop_wr(8'h02);
    `CHK("run", 1'b0, run)
    `CHK("osc", 1'b0, osc)
    `CHK("xgnd", 1'b1, xg)
    `CHK("hold", 7'h7f, st)
    nmi = 1'b0;
    tick(10);
    `CHK("stop", 1'b1, stopd)
    nmi = 1'b1;
    wait_hi(run, "run", n);
    `CHK("settle", 1'b1, n > 2 * UNIT)
    wait_hi(ack, "ack", n);
    `CHK("src", 2'h0, asrc)
    note("nmi");
    msk = 4'h4;
    mse = 4'h2;
    xsys = 1'b1;
    tick(2);
    stop_wr(8'h02);
    `CHK("xgnd", 1'b0, xg)
    pulse(wa);
    pulse(wb);
    tick(20);
    `CHK("stop", 1'b1, stopd)
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(1);
    `CHK("stop", 1'b0, stopd)
    msk = 4'h0;
    mse = 4'h0;
    ien = 1'b1;
    tick(2);
    stop_wr(8'h02);
    pulse(wa);
    wait_hi(ack, "ack", n);
    `CHK("src", 2'h1, asrc)
    note("maskable");
    ien = 1'b0;
    stop_wr(8'h02);
    pulse(wb);
    wait_hi(rsm, "resume", n);
    `CHK("pend", 4'h4, pend)
    ien = 1'b1;
    wait_hi(ack, "ack", n);
    `CHK("src", 2'h2, asrc)
    svc = 1'b1;
    tick(1);
    pulse(wt);
    tick(3);
    `CHK("pend", 4'h8, pend)
    stop_wr(8'h02);
    `CHK("run", 1'b1, run)
    wait_hi(rsm, "resume", n);
    relax = 1'b0;
    wait_hi(ack, "ack", n);
    `CHK("src", 2'h3, asrc)
    note("priority");
    svc = 1'b0;
    busy = 1'b1;
    nr = 1'b0;
    tick(2);
    stop_wr(8'h02);
    nmi = 1'b0;
    wait_hi(rsm, "resume", n);
    `CHK("pend", 4'h1, pend)
    busy = 1'b0;
    wait_hi(ack, "ack", n);
    `CHK("src", 2'h0, asrc)
    note("busy");
    stop_test();
  end
endmodule
